/* slt_stairway_light_switch.sv */
`timescale 1ns/1ns
module slt_stairway_light_switch #(
  parameter int unsigned TICK_CYCLES = slt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  // Block inputs, from outside the clock domain
  input  wire logic             trigger_in,
  input  wire logic             clear_in,
  // Interval settings
  input  wire slt_pkg::slt_cfg_t cfg_in,
  // Block outputs
  output logic                  switch_out,
  output slt_pkg::slt_value_t   value_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // A prescaler of zero cycles cannot mark a time unit, so it is refused.
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least one");
  end

  // The prescaler counts from zero up to one below the unit length.
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stage feeds only the second.
  // Both block inputs come from outside the clock domain.
  // The edge detector starts at the idle low level of the trigger,
  // so no false rising edge follows reset.
  // Each input reaches the sequencer two cycles after it is sampled.

  logic [1:0] trg_sync_r;
  logic [1:0] trg_sync_nxt;
  logic [1:0] clr_sync_r;
  logic [1:0] clr_sync_nxt;
  logic       trg_last_r;
  logic       trg_last_nxt;

  always_comb begin
    trg_sync_nxt = {trg_sync_r[0], trigger_in};
    clr_sync_nxt = {clr_sync_r[0], clear_in};
    trg_last_nxt = trg_sync_r[1];
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      trg_sync_r <= 2'h0;
      clr_sync_r <= 2'h0;
      trg_last_r <= 1'b0;
    end else begin
      trg_sync_r <= trg_sync_nxt;
      clr_sync_r <= clr_sync_nxt;
      trg_last_r <= trg_last_nxt;
    end
  end

  logic trg_rise;
  logic trg_fall;
  logic clr_lvl;
  assign trg_rise = trg_sync_r[1] & ~trg_last_r;
  assign trg_fall = ~trg_sync_r[1] & trg_last_r;
  assign clr_lvl  = clr_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  // The prescaler marks each 10 ms unit and the elapsed count adds units.
  // A phase ends on the unit tick that brings elapsed up to its limit.
  // The limit is read live, so a setting changed mid-phase takes effect
  // at once; a user who needs a fixed phase must hold the settings still.
  // Clear has the highest priority, then a rising trigger edge, which
  // restarts the sequence from any phase with the lamp lit.
  // A falling edge only counts while the sequence waits for it.

  slt_pkg::slt_state_t           state_r;
  slt_pkg::slt_state_t           state_nxt;
  logic [TW-1:0]                 tick_r;
  logic [TW-1:0]                 tick_nxt;
  logic [slt_pkg::IVL_W-1:0]     elapsed_r;
  logic [slt_pkg::IVL_W-1:0]     elapsed_nxt;
  logic                          out_r;
  logic                          out_nxt;
  logic [slt_pkg::IVL_W-1:0]     limit;
  logic                          tick_done;
  logic                          ivl_done;

  // Settings below the minimum are treated as one unit so a phase never
  // collapses to zero length.
  function automatic logic [slt_pkg::IVL_W-1:0] clamp(input logic [slt_pkg::IVL_W-1:0] v);
    if (v < slt_pkg::IVL_MIN) begin
      return slt_pkg::IVL_MIN;
    end else if (v > slt_pkg::IVL_MAX) begin
      return slt_pkg::IVL_MAX;
    end
    return v;
  endfunction

  always_comb begin
    case (state_r)
      slt_pkg::SLT_HOLD: limit = clamp(cfg_in.hold_time);
      slt_pkg::SLT_GAP:  limit = clamp(cfg_in.gap_time);
      slt_pkg::SLT_REON: limit = clamp(cfg_in.rehold_time);
      default:           limit = slt_pkg::IVL_MIN;
    endcase
    tick_done = (tick_r == TW'(TICK_CYCLES - 1));
    ivl_done  = tick_done && (elapsed_r + slt_pkg::IVL_MIN >= limit);
  end

  always_comb begin
    state_nxt   = state_r;
    out_nxt     = out_r;
    tick_nxt    = tick_r;
    elapsed_nxt = elapsed_r;
    if (clr_lvl) begin
      state_nxt   = slt_pkg::SLT_IDLE;
      out_nxt     = 1'b0;
      tick_nxt    = '0;
      elapsed_nxt = slt_pkg::IVL_ZERO;
    end else if (trg_rise) begin
      state_nxt   = slt_pkg::SLT_ARMED;
      out_nxt     = 1'b1;
      tick_nxt    = '0;
      elapsed_nxt = slt_pkg::IVL_ZERO;
    end else if (trg_fall && state_r == slt_pkg::SLT_ARMED) begin
      state_nxt   = slt_pkg::SLT_HOLD;
      tick_nxt    = '0;
      elapsed_nxt = slt_pkg::IVL_ZERO;
    end else begin
      case (state_r)
        slt_pkg::SLT_HOLD, slt_pkg::SLT_GAP, slt_pkg::SLT_REON: begin
          tick_nxt = tick_done ? '0 : tick_r + TW'(1);
          if (tick_done) begin
            elapsed_nxt = elapsed_r + slt_pkg::IVL_MIN;
          end
          if (ivl_done) begin
            tick_nxt    = '0;
            elapsed_nxt = slt_pkg::IVL_ZERO;
            case (state_r)
              slt_pkg::SLT_HOLD: begin
                state_nxt = slt_pkg::SLT_GAP;
                out_nxt   = 1'b0;
              end
              slt_pkg::SLT_GAP: begin
                state_nxt = slt_pkg::SLT_REON;
                out_nxt   = 1'b1;
              end
              default: begin
                state_nxt = slt_pkg::SLT_IDLE;
                out_nxt   = 1'b0;
              end
            endcase
          end
        end
        default: begin
          tick_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r   <= slt_pkg::SLT_IDLE;
      out_r     <= 1'b0;
      tick_r    <= '0;
      elapsed_r <= slt_pkg::IVL_ZERO;
    end else begin
      state_r   <= state_nxt;
      out_r     <= out_nxt;
      tick_r    <= tick_nxt;
      elapsed_r <= elapsed_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Value output is registered every cycle so readers see a steady word.
  // The word trails the sequencer by one cycle; that lag was traded for
  // a clean flip-flop output toward the panel and the comparator.
  // Phase and elapsed are taken together, so a reader never sees a count
  // of one phase beside the code of another.

  slt_pkg::slt_value_t value_r;
  slt_pkg::slt_value_t value_nxt;

  always_comb begin
    value_nxt.phase   = state_r;
    value_nxt.elapsed = elapsed_r;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      value_r <= '0;
    end else begin
      value_r <= value_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // The lamp output comes straight from its flip-flop, free of glitches.

  assign switch_out = out_r;
  assign value_out  = value_r;

endmodule // slt_stairway_light_switch

/* slt_pkg.sv */
package slt_pkg;

  // Time base: one count of an interval is 10 ms.
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

  // Interval range in 10 ms units: 10 ms up to 999:59:59.990.
  localparam int unsigned IVL_W         = 29;
  localparam logic [IVL_W-1:0] IVL_MIN  = 29'h0000001;
  localparam logic [IVL_W-1:0] IVL_MAX  = 29'h157529ff;
  localparam logic [IVL_W-1:0] IVL_ZERO = 29'h0000000;

  typedef enum logic [2:0] {
    SLT_IDLE  = 3'h0,
    SLT_ARMED = 3'h1,
    SLT_HOLD  = 3'h2,
    SLT_GAP   = 3'h3,
    SLT_REON  = 3'h4
  } slt_state_t;

  // The three interval settings, each in 10 ms units.
  typedef struct packed {
    logic [IVL_W-1:0] hold_time;
    logic [IVL_W-1:0] gap_time;
    logic [IVL_W-1:0] rehold_time;
  } slt_cfg_t;

  // Published running value: phase and elapsed count within it.
  typedef struct packed {
    slt_state_t       phase;
    logic [IVL_W-1:0] elapsed;
  } slt_value_t;

endpackage

/* slt_ctl_model.sv */
`timescale 1ns/1ns
module slt_ctl_model (
  input  wire logic clock_in,
  output logic      trig_out,
  output logic      clr_out
);
  initial {trig_out, clr_out} = 2'h0;
  // Levels stay whole cycles, as narrow pulses would slip past the synchroniser.
  task automatic hold(input logic t, input logic c, input int n);
    @(negedge clock_in);
    {trig_out, clr_out} = {t, c};
    repeat (n - 1) @(negedge clock_in);
  endtask
endmodule // slt_ctl_model

/* slt_sva.sv */
`timescale 1ns/1ns
module slt_sva #(parameter int unsigned TICK_CYCLES = 4) (
  input wire logic                clock_in,
  input wire logic                rst_in,
  input wire logic                trigger_in,
  input wire logic                clear_in,
  input wire slt_pkg::slt_cfg_t   cfg_in,
  input wire logic                switch_out,
  input wire slt_pkg::slt_value_t value_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_reset_clears: assert property (disable iff (1'b0)
    rst_in |=> !switch_out && value_out == '0) else $error("reset fail");
  a_clear_wins: assert property (clear_in [*3] |=> !switch_out)
    else $error("clear fail");
  a_rise_lights: assert property (!clear_in [*3] ##0 !trigger_in ##1
    (trigger_in && !clear_in) [*2] |-> ##2 switch_out) else $error("rise fail");
  a_idle_dark: assert property (value_out.phase == slt_pkg::SLT_IDLE |->
    !$past(switch_out)) else $error("idle fail");
  a_hold_lit: assert property (value_out.phase == slt_pkg::SLT_HOLD |->
    $past(switch_out)) else $error("hold fail");
  a_gap_dark: assert property (value_out.phase == slt_pkg::SLT_GAP |->
    !$past(switch_out)) else $error("gap fail");
  a_reon_lit: assert property (value_out.phase == slt_pkg::SLT_REON |->
    $past(switch_out)) else $error("reon fail");
  a_gap_count: assert property (value_out.phase == slt_pkg::SLT_GAP |->
    value_out.elapsed <= cfg_in.gap_time) else $error("count fail");
  c_reon: cover property (value_out.phase == slt_pkg::SLT_REON);
  c_gap: cover property (value_out.phase == slt_pkg::SLT_GAP);
  c_clear: cover property (clear_in [*3] ##1 !switch_out);
endmodule // slt_sva

/* slt_stairway_light_switch_tb.sv */
`timescale 1ns/1ns
module slt_stairway_light_switch_tb;
  logic                clock_in, rst_in, trigger_in, clear_in, switch_out;
  slt_pkg::slt_cfg_t   cfg_in;
  slt_pkg::slt_value_t value_out;
  int                  n_mismatch, checks_done;
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  slt_ctl_model u_src (.clock_in(clock_in), .trig_out(trigger_in), .clr_out(clear_in));
  slt_stairway_light_switch #(.TICK_CYCLES(4)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .trigger_in(trigger_in), .clear_in(clear_in), .cfg_in(cfg_in),
    .switch_out(switch_out), .value_out(value_out));
  task automatic end_of_test;
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic t, c, input int n, input logic sw, input logic [2:0] ph);
    u_src.hold(t, c, n);
    chk(32'(switch_out), 32'(sw));
    chk(32'(value_out.phase), 32'(ph));
  endtask
  task automatic t_walk;
    step(1'b1, 1'b0, 6, 1'b1, slt_pkg::SLT_ARMED);
    step(1'b0, 1'b0, 7, 1'b1, slt_pkg::SLT_HOLD);
    step(1'b0, 1'b0, 10, 1'b0, slt_pkg::SLT_GAP);
    chk(32'(value_out.elapsed), 32'h1);
    step(1'b0, 1'b0, 12, 1'b1, slt_pkg::SLT_REON);
    step(1'b0, 1'b0, 10, 1'b0, slt_pkg::SLT_IDLE);
  endtask
  task automatic t_clear;
    step(1'b1, 1'b0, 6, 1'b1, slt_pkg::SLT_ARMED);
    step(1'b1, 1'b1, 6, 1'b0, slt_pkg::SLT_IDLE);
    step(1'b0, 1'b1, 3, 1'b0, slt_pkg::SLT_IDLE);
    step(1'b1, 1'b1, 6, 1'b0, slt_pkg::SLT_IDLE);
    step(1'b0, 1'b0, 6, 1'b0, slt_pkg::SLT_IDLE);
  endtask
  task automatic t_rst;
    step(1'b1, 1'b0, 6, 1'b1, slt_pkg::SLT_ARMED);
    step(1'b0, 1'b0, 8, 1'b1, slt_pkg::SLT_HOLD);
    rst_in = 1'b1;
    step(1'b0, 1'b0, 3, 1'b0, slt_pkg::SLT_IDLE);
    rst_in = 1'b0;
  endtask
  initial begin
    rst_in = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    cfg_in = {29'h2, 29'h3, 29'h2};
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    t_walk();
    t_clear();
    t_rst();
    end_of_test();
  end
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule // slt_stairway_light_switch_tb
bind slt_stairway_light_switch slt_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clock_in(clock_in), .rst_in(rst_in), .trigger_in(trigger_in), .clear_in(clear_in),
  .cfg_in(cfg_in), .switch_out(switch_out), .value_out(value_out));
